/* File: rtc_pkg.sv */
// Constants and types for the RTC timebase and two-wire register block
package rtc_pkg;
  // Timebase
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned HT_HZ = 65_536; // Half periods of 32.768 kHz
  localparam logic [27:0] ACC_STEP = 28'(HT_HZ);
  localparam logic [27:0] ACC_WRAP = 28'(CLK_HZ);
  localparam int TAP_32K = 0;
  localparam int TAP_4096 = 3;
  localparam int TAP_1024 = 5;
  localparam int TAP_64 = 9;
  localparam int TAP_32 = 10;
  localparam int TAP_1 = 15;
  localparam logic [5:0] PRE_HALF = 6'h1F;
  // Pulsed interrupt lengths, in half periods of 32.768 kHz
  localparam logic [10:0] P_8192 = 11'(HT_HZ / 8192);
  localparam logic [10:0] P_4096 = 11'(HT_HZ / 4096);
  localparam logic [10:0] P_128 = 11'(HT_HZ / 128);
  localparam logic [10:0] P_64 = 11'(HT_HZ / 64);
  // Register offsets
  localparam logic [3:0] REG_CTRL1 = 4'h0;
  localparam logic [3:0] REG_CTRL2 = 4'h1;
  localparam logic [3:0] REG_SEC = 4'h2;
  localparam logic [3:0] REG_MIN = 4'h3;
  localparam logic [3:0] REG_HOUR = 4'h4;
  localparam logic [3:0] REG_DAY = 4'h5;
  localparam logic [3:0] REG_WDAY = 4'h6;
  localparam logic [3:0] REG_MON = 4'h7;
  localparam logic [3:0] REG_YEAR = 4'h8;
  localparam logic [3:0] REG_CLOCK_OUTPUT_PIN = 4'hD;
  localparam logic [3:0] REG_TCTL = 4'hE;
  localparam logic [3:0] REG_TVAL = 4'hF;
  // Field positions
  localparam int B_TEST = 7;
  localparam int B_STOP = 5;
  localparam int B_PERMIT = 3;
  localparam int B_PULSE = 4;
  localparam int B_FLAG = 2;
  localparam int B_TIE = 0;
  localparam int B_ENABLE = 7;
  localparam int B_CENTURY = 7;
  // Field masks and BCD ranges
  localparam logic [7:0] M_SEC = 8'h7F;
  localparam logic [7:0] M_HOUR = 8'h3F;
  localparam logic [7:0] M_WDAY = 8'h07;
  localparam logic [7:0] M_MON = 8'h1F;
  localparam logic [7:0] M_YEAR = 8'hFF;
  localparam logic [7:0] BCD_0 = 8'h00;
  localparam logic [7:0] BCD_1 = 8'h01;
  localparam logic [7:0] BCD_59 = 8'h59;
  localparam logic [7:0] BCD_23 = 8'h23;
  localparam logic [7:0] WDAY_SAT = 8'h06;
  localparam logic [7:0] BCD_12 = 8'h12;
  localparam logic [7:0] BCD_99 = 8'h99;
  localparam logic [7:0] BCD_FEB = 8'h02;
  // Reset values
  localparam logic [7:0] CTRL1_RST = 8'h08;
  localparam logic [7:0] CLOCK_OUTPUT_PIN_RST = 8'h80;
  localparam logic [7:0] TCTL_RST = 8'h03;
  localparam logic [7:0] DATE_RST = 8'h01;

  typedef struct packed {
    logic scl;
    logic sda;
    logic ck;
  } rtc_lines_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACKA, ST_WORD, ST_ACKW, ST_WR, ST_RD, ST_RACK
  } rtc_i2c_st_t;
endpackage

/* File: rtc_timebase.sv */
// RTC timebase, calendar, countdown timer and two-wire register slave
`timescale 1ns/1ps
// Behaviour
// R01: February gets day 29 when the BCD year is divisible by four, 00 too.
// R02: Pulsed interrupt length follows timer source and whether count is one.
// R03: Countdown stays stopped with no events while its loaded value is zero.
// R04: Timer flag and interrupt output assert in the same cycle.
// R05: Clock-out select 00/01/10/11 gives 32.768 kHz, 1024, 32, 1 Hz.
// R06: Timer source select 00/01/10/11 gives 4096, 64, 1, 1/60 Hz.
// R07: Weekday lives in bits 2:0, Sunday 0 to Saturday 6.
// R08: Month is BCD in bits 4:0; bit 7 is the century flag.
// R09: Test bit makes the clock-out pin an input replacing 64 Hz.
// R10: In test mode every 64 rising pin edges advance seconds by one.
// R11: Stop bit clears the prescaler and holds it at zero.
// R12: After stop release, first second after 32 edges, then every 64.
// R13: Software uses the stop bit to get a known prescaler state.
// R14: Recognised reset override releases internal reset at once.
// R15: Writing permit bit 0 cancels override and blocks re-entry until 1.
// R16: SDA falling with SCL high is start; rising is stop.
// R17: SDA changes while SCL high are taken as start or stop only.
// R18: Addressed receiver pulls SDA low over the ninth clock of each byte.
// R19: Master nack ends a read; device releases SDA for the stop.
// R20: Clock-out enable low drives the pin low; high outputs the frequency.
// R21: Override pin sequence comes from outside as a recognised pulse.
// R22: Clearing test mode restores pin output and internal 64 Hz.
module rtc_timebase #(
  parameter logic [6:0] SLAVE_ADDR = 7'h2A // Arbitrary value
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic clock_output_pin_i,
  output logic clock_output_pin_o,
  output logic clock_output_pin_oe_o,
  output logic int_n_o,
  input wire logic por_busy_i,
  input wire logic por_override_i,
  output logic por_held_o
);
  rtc_pkg::rtc_lines_t s1, s2, s3, stab, next_stab;
  logic [27:0] acc, next_acc;
  logic [15:0] c16, next_c16;
  logic [5:0] pre, next_pre;
  logic [7:0] regs [16];
  logic [7:0] next_regs [16];
  logic [7:0] cnt, next_cnt;
  logic [10:0] pcnt, next_pcnt;
  logic ovr, next_ovr;
  rtc_pkg::rtc_i2c_st_t st, next_st;
  logic [2:0] bcnt, next_bcnt;
  logic [7:0] sh, next_sh;
  logic [3:0] ptr, next_ptr;
  logic mack, next_mack;
  logic next_oe, next_ck, next_int_n;
  logic ht, tick64, sec_tick, min_tick, evt, in_reset;
  logic scl_rise, scl_fall, start_c, stop_c;
  logic wr_en;
  logic [7:0] din, rbyte;

  function automatic logic rises(input logic [15:0] c, input int k);
    logic [15:0] c1;
    c1 = c + 16'h0001;
    return c1[k] & ~c[k];
  endfunction

  function automatic logic [8:0] bcd_inc(input logic [7:0] v, lo, hi);
    if (v >= hi) return {1'b1, lo};
    if (v[3:0] == 4'h9) return {1'b0, v[7:4] + 4'h1, 4'h0};
    return {1'b0, v + 8'h01};
  endfunction

  // Carry out in bit 8; bits outside the mask are kept
  function automatic logic [8:0] step(input logic [7:0] v, m, lo, hi);
    logic [8:0] r;
    r = bcd_inc(v & m, lo, hi);
    return {r[8], (v & ~m) | (r[7:0] & m)};
  endfunction

  // Pins: a change counts once stages two and three agree
  always_comb begin
    next_stab = (s3 & ~(s2 ^ s3)) | (stab & (s2 ^ s3));
    scl_rise = next_stab.scl & ~stab.scl;
    scl_fall = ~next_stab.scl & stab.scl;
    start_c = stab.scl & next_stab.scl & stab.sda & ~next_stab.sda; // R16
    stop_c = stab.scl & next_stab.scl & ~stab.sda & next_stab.sda; // R16
  end

  // Timebase and prescaler
  always_comb begin
    next_acc = acc + rtc_pkg::ACC_STEP;
    ht = next_acc >= rtc_pkg::ACC_WRAP;
    if (ht) next_acc = next_acc - rtc_pkg::ACC_WRAP;
    next_c16 = ht ? c16 + 16'h0001 : c16;
    if (regs[rtc_pkg::REG_CTRL1][rtc_pkg::B_TEST]) begin
      tick64 = next_stab.ck & ~stab.ck; // R09 R10
    end else begin
      tick64 = ht & rises(c16, rtc_pkg::TAP_64); // R22
    end
    // Stop zeroes the 64 Hz prescaler so tests start from a known phase
    if (regs[rtc_pkg::REG_CTRL1][rtc_pkg::B_STOP]) begin
      next_pre = 6'h00; // R11 R13
    end else begin
      next_pre = tick64 ? pre + 6'h01 : pre; // R10
    end
    sec_tick = tick64 & ~in_reset & (pre == rtc_pkg::PRE_HALF) &
      ~regs[rtc_pkg::REG_CTRL1][rtc_pkg::B_STOP]; // R12
    unique case (regs[rtc_pkg::REG_CLOCK_OUTPUT_PIN][1:0]) // R05
      2'h0: next_ck = c16[rtc_pkg::TAP_32K];
      2'h1: next_ck = c16[rtc_pkg::TAP_1024];
      2'h2: next_ck = c16[rtc_pkg::TAP_32];
      2'h3: next_ck = c16[rtc_pkg::TAP_1];
    endcase
    next_ck = next_ck & regs[rtc_pkg::REG_CLOCK_OUTPUT_PIN][rtc_pkg::B_ENABLE]; // R20
  end

  // Reset override
  always_comb begin
    in_reset = por_busy_i & ~ovr; // R14
    next_ovr = ovr;
    if (por_override_i && regs[rtc_pkg::REG_CTRL1][rtc_pkg::B_PERMIT]) begin
      next_ovr = 1'b1; // R14 R21
    end
    if (wr_en && ptr == rtc_pkg::REG_CTRL1 && !din[rtc_pkg::B_PERMIT]) begin
      next_ovr = 1'b0; // R15
    end
  end

  // Countdown timer and interrupt
  always_comb begin
    logic stick;
    logic one;
    logic [10:0] plen;
    logic act;
    stick = 1'b0;
    plen = rtc_pkg::P_64;
    act = 1'b0;
    one = regs[rtc_pkg::REG_TVAL] == 8'h01;
    unique case (regs[rtc_pkg::REG_TCTL][1:0]) // R06
      2'h0: stick = ht & rises(c16, rtc_pkg::TAP_4096);
      2'h1: stick = ht & rises(c16, rtc_pkg::TAP_64);
      2'h2: stick = sec_tick;
      2'h3: stick = min_tick;
    endcase
    unique case (regs[rtc_pkg::REG_TCTL][1:0]) // R02
      2'h0: plen = one ? rtc_pkg::P_8192 : rtc_pkg::P_4096;
      2'h1: plen = one ? rtc_pkg::P_128 : rtc_pkg::P_64;
      2'h2, 2'h3: plen = rtc_pkg::P_64;
    endcase
    evt = 1'b0;
    next_cnt = cnt;
    if (wr_en && ptr == rtc_pkg::REG_TVAL) begin
      next_cnt = din;
    end else if (regs[rtc_pkg::REG_TCTL][rtc_pkg::B_ENABLE] && stick &&
                 regs[rtc_pkg::REG_TVAL] != 8'h00) begin // R03
      if (cnt <= 8'h01) begin
        evt = 1'b1;
        next_cnt = regs[rtc_pkg::REG_TVAL];
      end else begin
        next_cnt = cnt - 8'h01;
      end
    end
    next_pcnt = pcnt;
    if (evt && regs[rtc_pkg::REG_CTRL2][rtc_pkg::B_PULSE]) begin
      next_pcnt = plen; // R02
    end else if (ht && pcnt != 11'h000) begin
      next_pcnt = pcnt - 11'h001;
    end
    if (regs[rtc_pkg::REG_CTRL2][rtc_pkg::B_PULSE]) begin
      act = next_pcnt != 11'h000;
    end else begin
      act = next_regs[rtc_pkg::REG_CTRL2][rtc_pkg::B_FLAG];
    end
    next_int_n = ~(act & regs[rtc_pkg::REG_CTRL2][rtc_pkg::B_TIE]); // R04
  end

  // Calendar, register writes, flag
  always_comb begin
    logic [8:0] r;
    logic c;
    logic [7:0] mon;
    logic [7:0] dim;
    logic leap;
    dim = 8'h31;
    next_regs = regs;
    c = sec_tick;
    r = step(regs[rtc_pkg::REG_SEC], rtc_pkg::M_SEC, rtc_pkg::BCD_0,
      rtc_pkg::BCD_59);
    if (c) next_regs[rtc_pkg::REG_SEC] = r[7:0];
    c = c & r[8];
    min_tick = c;
    r = step(regs[rtc_pkg::REG_MIN], rtc_pkg::M_SEC, rtc_pkg::BCD_0,
      rtc_pkg::BCD_59);
    if (c) next_regs[rtc_pkg::REG_MIN] = r[7:0];
    c = c & r[8];
    r = step(regs[rtc_pkg::REG_HOUR], rtc_pkg::M_HOUR, rtc_pkg::BCD_0,
      rtc_pkg::BCD_23);
    if (c) next_regs[rtc_pkg::REG_HOUR] = r[7:0];
    c = c & r[8];
    r = step(regs[rtc_pkg::REG_WDAY], rtc_pkg::M_WDAY, rtc_pkg::BCD_0,
      rtc_pkg::WDAY_SAT);
    if (c) next_regs[rtc_pkg::REG_WDAY] = r[7:0]; // R07
    mon = regs[rtc_pkg::REG_MON] & rtc_pkg::M_MON;
    // Ten is two modulo four, so only the tens parity matters
    leap = (regs[rtc_pkg::REG_YEAR][1:0] +
      {regs[rtc_pkg::REG_YEAR][4], 1'b0}) == 2'h0; // R01
    if (mon == rtc_pkg::BCD_FEB) begin
      dim = leap ? 8'h29 : 8'h28; // R01
    end else if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 ||
                 mon == 8'h11) begin
      dim = 8'h30;
    end else begin
      dim = 8'h31;
    end
    r = step(regs[rtc_pkg::REG_DAY], rtc_pkg::M_HOUR, rtc_pkg::BCD_1, dim);
    if (c) next_regs[rtc_pkg::REG_DAY] = r[7:0];
    c = c & r[8];
    r = step(regs[rtc_pkg::REG_MON], rtc_pkg::M_MON, rtc_pkg::BCD_1,
      rtc_pkg::BCD_12);
    if (c) next_regs[rtc_pkg::REG_MON] = r[7:0]; // R08
    c = c & r[8];
    r = step(regs[rtc_pkg::REG_YEAR], rtc_pkg::M_YEAR, rtc_pkg::BCD_0,
      rtc_pkg::BCD_99);
    if (c) next_regs[rtc_pkg::REG_YEAR] = r[7:0];
    if (c && r[8]) begin
      next_regs[rtc_pkg::REG_MON][rtc_pkg::B_CENTURY] =
        ~regs[rtc_pkg::REG_MON][rtc_pkg::B_CENTURY]; // R08
    end
    if (wr_en) begin
      next_regs[ptr] = din;
      if (ptr == rtc_pkg::REG_CTRL2) begin
        next_regs[ptr][rtc_pkg::B_FLAG] = din[rtc_pkg::B_FLAG] &
          regs[ptr][rtc_pkg::B_FLAG];
      end
    end
    // Hardware set wins over a clearing write
    if (evt) next_regs[rtc_pkg::REG_CTRL2][rtc_pkg::B_FLAG] = 1'b1; // R04
  end

  // Two-wire slave
  always_comb begin
    next_st = st;
    next_bcnt = bcnt;
    next_sh = sh;
    next_ptr = ptr;
    next_oe = sda_oe_o;
    next_mack = mack;
    wr_en = 1'b0;
    din = {sh[6:0], next_stab.sda};
    rbyte = (ptr == rtc_pkg::REG_TVAL) ? cnt : regs[ptr];
    if (in_reset || stop_c) begin
      next_st = rtc_pkg::ST_IDLE; // R16
      next_oe = 1'b0;
    end else if (start_c) begin
      next_st = rtc_pkg::ST_ADDR; // R16 R17
      next_bcnt = 3'h0;
      next_oe = 1'b0;
    end else if (scl_rise) begin
      unique case (st)
        rtc_pkg::ST_ADDR, rtc_pkg::ST_WORD, rtc_pkg::ST_WR: begin
          next_sh = din;
          next_bcnt = bcnt + 3'h1;
          if (bcnt == 3'h7) begin
            if (st == rtc_pkg::ST_ADDR) begin
              next_st = (din[7:1] == SLAVE_ADDR) ? rtc_pkg::ST_ACKA :
                rtc_pkg::ST_IDLE;
            end else if (st == rtc_pkg::ST_WORD) begin
              next_ptr = din[3:0];
              next_st = rtc_pkg::ST_ACKW;
            end else begin
              wr_en = 1'b1;
              next_ptr = ptr + 4'h1;
              next_st = rtc_pkg::ST_ACKW;
            end
          end
        end
        rtc_pkg::ST_RACK: next_mack = ~next_stab.sda; // R19
        rtc_pkg::ST_IDLE, rtc_pkg::ST_ACKA, rtc_pkg::ST_ACKW,
        rtc_pkg::ST_RD: ;
      endcase
    end else if (scl_fall) begin
      unique case (st)
        rtc_pkg::ST_ACKA, rtc_pkg::ST_ACKW: begin
          next_bcnt = 3'h0;
          if (!sda_oe_o) begin
            next_oe = 1'b1; // R18
          end else if (st == rtc_pkg::ST_ACKA && sh[0]) begin
            next_sh = rbyte;
            next_ptr = ptr + 4'h1;
            next_oe = ~rbyte[7];
            next_st = rtc_pkg::ST_RD;
          end else begin
            next_oe = 1'b0;
            next_st = (st == rtc_pkg::ST_ACKA) ? rtc_pkg::ST_WORD :
              rtc_pkg::ST_WR;
          end
        end
        rtc_pkg::ST_RD: begin
          if (bcnt == 3'h7) begin
            next_oe = 1'b0; // R19
            next_st = rtc_pkg::ST_RACK;
          end else begin
            next_sh = {sh[6:0], 1'b0};
            next_oe = ~sh[6];
            next_bcnt = bcnt + 3'h1;
          end
        end
        rtc_pkg::ST_RACK: begin
          next_bcnt = 3'h0;
          if (mack) begin
            next_sh = rbyte;
            next_ptr = ptr + 4'h1;
            next_oe = ~rbyte[7];
            next_st = rtc_pkg::ST_RD;
          end else begin
            next_st = rtc_pkg::ST_IDLE; // R19
          end
        end
        rtc_pkg::ST_IDLE, rtc_pkg::ST_ADDR, rtc_pkg::ST_WORD,
        rtc_pkg::ST_WR: ;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1 <= '1;
      s2 <= '1;
      s3 <= '1;
      stab <= '1;
      acc <= 28'h000_0000;
      c16 <= 16'h0000;
      pre <= 6'h00;
      for (int i = 0; i < 16; i++) begin
        regs[i] <= 8'h00;
      end
      regs[rtc_pkg::REG_CTRL1] <= rtc_pkg::CTRL1_RST;
      regs[rtc_pkg::REG_CLOCK_OUTPUT_PIN] <= rtc_pkg::CLOCK_OUTPUT_PIN_RST;
      regs[rtc_pkg::REG_TCTL] <= rtc_pkg::TCTL_RST;
      regs[rtc_pkg::REG_DAY] <= rtc_pkg::DATE_RST;
      regs[rtc_pkg::REG_MON] <= rtc_pkg::DATE_RST;
      cnt <= 8'h00;
      pcnt <= 11'h000;
      ovr <= 1'b0;
      st <= rtc_pkg::ST_IDLE;
      bcnt <= 3'h0;
      sh <= 8'h00;
      ptr <= 4'h0;
      mack <= 1'b0;
      sda_o <= 1'b0;
      sda_oe_o <= 1'b0;
      clock_output_pin_o <= 1'b0;
      clock_output_pin_oe_o <= 1'b0;
      int_n_o <= 1'b1;
      por_held_o <= 1'b1;
    end else begin
      s1 <= {scl_i, sda_i, clock_output_pin_i};
      s2 <= s1;
      s3 <= s2;
      stab <= next_stab;
      acc <= next_acc;
      c16 <= next_c16;
      pre <= next_pre;
      regs <= next_regs;
      cnt <= next_cnt;
      pcnt <= next_pcnt;
      ovr <= next_ovr;
      st <= next_st;
      bcnt <= next_bcnt;
      sh <= next_sh;
      ptr <= next_ptr;
      mack <= next_mack;
      sda_o <= 1'b0;
      sda_oe_o <= next_oe;
      // Same edge as the enable, so a released pin never shows a high
      clock_output_pin_o <= next_ck &
        ~next_regs[rtc_pkg::REG_CTRL1][rtc_pkg::B_TEST]; // R09
      clock_output_pin_oe_o <= ~next_regs[rtc_pkg::REG_CTRL1][rtc_pkg::B_TEST]; // R09
      int_n_o <= next_int_n;
      por_held_o <= in_reset;
    end
  end
endmodule

/* File: rtc_timebase_properties.sv */
// Port checker for the RTC timebase block
`timescale 1ns/1ps
module rtc_timebase_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic clock_output_pin_i,
  input wire logic clock_output_pin_o,
  input wire logic clock_output_pin_oe_o,
  input wire logic int_n_o,
  input wire logic por_busy_i,
  input wire logic por_override_i,
  input wire logic por_held_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Pins pass three flops, so SDA moves a few cycles into SCL low
  ack_timing_a: assert property ($changed(sda_oe_o) |->
    !$past(scl_i, 3) && $past(scl_i, 8))
    else $error("SDA drive moved outside the SCL low phase");
  ack_hold_a: assert property ($rose(sda_oe_o) |-> sda_oe_o[*8])
    else $error("SDA drive shorter than one bit");
  sda_zero_a: assert property (sda_o == 1'b0)
    else $error("SDA output value not low");
  ack_stop_a: assert property (scl_i && $past(scl_i) && $rose(sda_i)
    |=> !sda_oe_o[*8])
    else $error("SDA driven right after a stop");
  por_free_a: assert property (!por_busy_i |=> !por_held_o)
    else $error("Block held without power-on reset");
  // Override pulse reaches the held output two edges later
  por_fall_a: assert property ($fell(por_held_o) |->
    $past(por_override_i, 2) || !$past(por_busy_i))
    else $error("Hold released without cause");
  held_quiet_a: assert property (por_held_o |-> !$rose(sda_oe_o))
    else $error("Slave answered while held");
  out_off_a: assert property (!clock_output_pin_oe_o |-> !clock_output_pin_o)
    else $error("Clock output high while pin released");
  ack_c: cover property ($rose(sda_oe_o));
  test_c: cover property ($fell(clock_output_pin_oe_o));
  irq_c: cover property ($fell(int_n_o));
endmodule

/* File: rtc_bm.sv */
// Two-wire bus master model for the register slave
`timescale 1ns/1ps
module rtc_bm #(
  parameter logic [6:0] SA = 7'h2A // Arbitrary value
) (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oe_o
);
  logic [7:0] dat [16];
  int nacks = 0;
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic start();
    sda_oe_o = 1'b1;
    w(16);
    scl_o = 1'b0;
    w(8);
  endtask
  task automatic stop();
    sda_oe_o = 1'b1;
    w(8);
    scl_o = 1'b1;
    w(8);
    sda_oe_o = 1'b0;
    w(24);
  endtask
  // SDA moves only mid-low so high phases stay clean
  task automatic bits(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      sda_oe_o = !tx[i];
      w(8);
      scl_o = 1'b1;
      w(8);
      rx[i] = sda_i;
      w(8);
      scl_o = 1'b0;
      w(8);
    end
  endtask
  task automatic put(input logic [7:0] b);
    logic [8:0] r;
    bits({b, 1'b1}, r);
    if (r[0]) begin
      nacks++;
    end
  endtask
  task automatic wr(input logic [3:0] p, input int n);
    start();
    put({SA, 1'b0});
    put({4'h0, p});
    for (int k = 0; k < n; k++) begin
      put(dat[k]);
    end
    stop();
  endtask
  task automatic rd(input logic [3:0] p, input int n);
    logic [8:0] r;
    wr(p, 0);
    start();
    put({SA, 1'b1});
    for (int k = 0; k < n; k++) begin
      bits({8'hFF, k == n - 1}, r);
      dat[k] = r[8:1];
    end
    stop();
  endtask
endmodule

/* File: rtc_timebase_tb_top.sv */
// Self-checking bench for the RTC timebase block
`timescale 1ns/1ps
module rtc_timebase_tb_top;
  localparam logic [6:0] SA = 7'h2A; // Arbitrary value
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ck_drv = 1'b0;
  logic busy = 1'b1;
  logic ovr = 1'b0;
  logic scl, m_oe, sda_oe, sda_o, ck_o, ck_oe, int_n, held;
  rtc_pkg::rtc_lines_t ln;
  logic [7:0] y;
  logic [7:0] ex [4];
  int n_errors = 0;
  int compares = 0;
  int seed = 32;
  int t;
  assign ln = {scl, !(m_oe | sda_oe), ck_oe ? ck_o : ck_drv};
  always #2 clk_i = ~clk_i;
  rtc_timebase #(.SLAVE_ADDR(SA)) i_rtc_timebase (.clk_i(clk_i),
    .rst_i(rst_i), .scl_i(ln.scl), .sda_i(ln.sda), .sda_o(sda_o),
    .sda_oe_o(sda_oe), .clock_output_pin_i(ln.ck), .clock_output_pin_o(ck_o),
    .clock_output_pin_oe_o(ck_oe), .int_n_o(int_n), .por_busy_i(busy),
    .por_override_i(ovr), .por_held_o(held));
  rtc_bm #(.SA(SA)) i_rtc_bm (.clk_i(clk_i), .sda_i(ln.sda),
    .scl_o(scl), .sda_oe_o(m_oe));
  task automatic complete_run();
    $display("Errors %0d of %0d compares", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    chk_byte({7'h00, g}, {7'h00, e});
  endtask
  task automatic stay(input logic irq, input int lim, output int c);
    logic v;
    v = irq ? int_n : ck_o;
    c = 0;
    while ((irq ? int_n : ck_o) === v && c < lim) begin
      @(negedge clk_i);
      c++;
    end
    if (c >= lim) begin
      n_errors++;
      complete_run();
    end
  endtask
  // Pin clock kept at a 1008 ns period, above the pin minimum
  task automatic edges(input int n);
    repeat (n) begin
      ck_drv = 1'b1;
      repeat (126) @(negedge clk_i);
      ck_drv = 1'b0;
      repeat (126) @(negedge clk_i);
    end
  endtask
  task automatic pulse_ovr();
    ovr = 1'b1;
    @(negedge clk_i);
    ovr = 1'b0;
    repeat (2) @(negedge clk_i);
  endtask
  task automatic put_regs(input logic [3:0] p, input int n,
                          input logic [71:0] v);
    for (int k = 0; k < n; k++) begin
      i_rtc_bm.dat[k] = v[8 * (n - 1 - k) +: 8];
    end
    i_rtc_bm.wr(p, n);
  endtask
  function automatic logic [7:0] rst_val(input int r);
    case (r)
      0: return rtc_pkg::CTRL1_RST;
      5, 7: return rtc_pkg::DATE_RST;
      13: return rtc_pkg::CLOCK_OUTPUT_PIN_RST;
      14: return rtc_pkg::TCTL_RST;
      default: return 8'h00;
    endcase
  endfunction
  function automatic logic leap(input logic [7:0] yr);
    return ((yr[7:4] * 10 + yr[3:0]) % 4) == 0;
  endfunction
  initial begin
    repeat (2) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (4) @(negedge clk_i);
    chk_bit(held, 1'b1);
    pulse_ovr();
    chk_bit(held, 1'b0);
    i_rtc_bm.rd(0, 16);
    for (int k = 0; k < 16; k++) begin
      chk_byte(i_rtc_bm.dat[k], rst_val(k));
    end
    // Enabled with reload zero; measures one 32.768 kHz clock-out half period
    put_regs(14, 2, 72'h8000);
    stay(0, 9000, t);
    stay(0, 9000, t);
    chk_bit(t >= 3813 && t <= 3816, 1'b1);
    put_regs(13, 1, 72'h03);
    chk_bit(ck_o, 1'b0);
    for (int k = 0; k < 4; k++) begin
      ex[k] = 8'($random(seed));
      i_rtc_bm.dat[k] = ex[k];
    end
    i_rtc_bm.wr(9, 4);
    i_rtc_bm.rd(9, 4);
    for (int k = 0; k < 4; k++) begin
      chk_byte(i_rtc_bm.dat[k], ex[k]);
    end
    for (int j = 0; j < 2; j++) begin
      t = ({$random(seed)} % 50) * 2 + 1;
      y = (j == 0) ? 8'h00 : {4'(t / 10), 4'(t % 10)};
      put_regs(0, 9, {64'hA805_5959_2328_0682, y});
      chk_bit(ck_oe, 1'b0);
      put_regs(0, 1, 72'h88);
      edges(31);
      i_rtc_bm.rd(2, 1);
      chk_byte(i_rtc_bm.dat[0], 8'h59);
      edges(1);
      i_rtc_bm.rd(2, 7);
      chk_byte(i_rtc_bm.dat[0], 8'h00);
      chk_byte(i_rtc_bm.dat[3], leap(y) ? 8'h29 : 8'h01);
      chk_byte(i_rtc_bm.dat[4] & 8'h07, 8'h00);
      chk_byte(i_rtc_bm.dat[5] & 8'h9F, leap(y) ? 8'h82 : 8'h83);
    end
    edges(63);
    i_rtc_bm.rd(2, 1);
    chk_byte(i_rtc_bm.dat[0], 8'h00);
    edges(1);
    i_rtc_bm.rd(2, 1);
    chk_byte(i_rtc_bm.dat[0], 8'h01);
    put_regs(0, 1, 72'h08);
    chk_bit(ck_oe, 1'b1);
    chk_bit(int_n, 1'b1);
    put_regs(14, 4, 72'h8001_0811);
    stay(1, 70000, t);
    stay(1, 40000, t);
    chk_bit(t >= 30514 && t <= 30522, 1'b1);
    i_rtc_bm.rd(1, 1);
    chk_byte(i_rtc_bm.dat[0] & 8'h04, 8'h04);
    put_regs(14, 1, 72'h03);
    chk_byte(8'(i_rtc_bm.nacks), 8'h00);
    put_regs(0, 1, 72'h00);
    chk_bit(held, 1'b1);
    pulse_ovr();
    chk_bit(held, 1'b1);
    busy = 1'b0;
    repeat (2) @(negedge clk_i);
    chk_bit(held, 1'b0);
    complete_run();
  end
endmodule
bind rtc_timebase rtc_timebase_properties i_rtc_timebase_properties (
  .clk_i(clk_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .clock_output_pin_i(clock_output_pin_i),
  .clock_output_pin_o(clock_output_pin_o), .clock_output_pin_oe_o(clock_output_pin_oe_o), .int_n_o(int_n_o),
  .por_busy_i(por_busy_i), .por_override_i(por_override_i),
  .por_held_o(por_held_o));
